//--- hw/bsr_alu_pkg.sv
// Shared types and constants for the bit shift and rotate datapath
package bsr_alu_pkg;

    localparam int DATA_WIDTH   = 32;
    localparam int COUNT_WIDTH  = 5;
    localparam int INDEX_WIDTH  = 5;
    localparam int COND_WIDTH   = 4;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam logic        FLAG_RESET   = 1'b0;
    localparam logic [7:0]  BYTE_ONE     = 8'h01;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_DOUBLE_SHIFT_LEFT,
        OP_DOUBLE_SHIFT_RIGHT,
        OP_ROTATE_LEFT_PLAIN,
        OP_ROTATE_RIGHT_PLAIN,
        OP_ROTATE_LEFT_VIA_CARRY,
        OP_ROTATE_RIGHT_VIA_CARRY,
        OP_BIT_TEST_ONLY,
        OP_BIT_TEST_THEN_SET,
        OP_BIT_TEST_THEN_CLEAR,
        OP_BIT_TEST_THEN_INVERT,
        OP_SCAN_UP_FIRST_ONE,
        OP_SCAN_DOWN_FIRST_ONE,
        OP_CONDITIONAL_BYTE_SET,
        OP_AND_TEST
    } bsralu_op_type;

    // Condition codes for the conditional byte set, in pairs with the negation
    typedef enum logic [3:0] {
        COND_OVERFLOW,
        COND_NO_OVERFLOW,
        COND_CARRY,
        COND_NO_CARRY,
        COND_ZERO,
        COND_NOT_ZERO,
        COND_CARRY_OR_ZERO,
        COND_ABOVE,
        COND_SIGN,
        COND_NO_SIGN,
        COND_PARITY,
        COND_NO_PARITY,
        COND_LESS,
        COND_GREATER_EQUAL,
        COND_LESS_EQUAL,
        COND_GREATER
    } bsralu_cond_type;

    typedef struct packed {
        logic carryFlag;
        logic overflowFlag;
        logic signFlag;
        logic zeroFlag;
        logic parityFlag;
    } bsralu_flags_type;

    typedef struct packed {
        bsralu_op_type           op;
        logic                    wordSize;
        logic [DATA_WIDTH-1:0]   dest;
        logic [DATA_WIDTH-1:0]   src;
        logic [COUNT_WIDTH-1:0]  count;
        bsralu_cond_type         cond;
    } bsralu_req_type;

endpackage : bsr_alu_pkg

//--- hw/bsr_alu_scan.sv
// Priority encoder for forward and reverse first-one search
`timescale 1ns/100ps
module bsr_alu_scan
    import bsr_alu_pkg::*;
#(
    parameter int WIDTH = DATA_WIDTH
)
(
    input  wire logic [WIDTH-1:0]        value,
    input  wire logic                    wordSize,
    output logic      [INDEX_WIDTH-1:0]  upIndex,
    output logic      [INDEX_WIDTH-1:0]  downIndex,
    output logic                         found
);

    always_comb
    begin
        upIndex   = '0;
        downIndex = '0;
        found     = 1'b0;
        // Upward: keep the lowest set bit
        for (int i = WIDTH - 1; i >= 0; i--)
        begin
            if (value[i] && !(wordSize && i >= WIDTH / 2))
            begin
                upIndex = INDEX_WIDTH'(i);
            end
        end
        // Downward: keep the highest set bit
        for (int i = 0; i < WIDTH; i++)
        begin
            if (value[i] && !(wordSize && i >= WIDTH / 2))
            begin
                downIndex = INDEX_WIDTH'(i);
                found     = 1'b1;
            end
        end
    end

endmodule : bsr_alu_scan

//--- hw/bsr_alu.sv
// Bit shift, rotate, bit test, scan, conditional byte set and AND test datapath
`timescale 1ns/100ps
module bsr_alu
    import bsr_alu_pkg::*;
#(
    parameter int WIDTH = DATA_WIDTH
)
(
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic                    reqValid,
    input  wire bsralu_req_type          req,
    input  wire bsralu_flags_type        flagsIn,
    output logic                         resultValid,
    output logic      [WIDTH-1:0]        result,
    output logic                         destWrite,
    output bsralu_flags_type             flagsOut
);

    // Even parity of the low byte, as the status flags define it
    function automatic logic even_parity(input logic [WIDTH-1:0] v);
        even_parity = ~^v[7:0];
    endfunction : even_parity

    function automatic logic [WIDTH-1:0] size_mask(input logic word);
        size_mask = word ? {{(WIDTH/2){1'b0}}, {(WIDTH/2){1'b1}}} : '1;
    endfunction : size_mask

    logic                    resultValidReg;
    logic [WIDTH-1:0]        resultReg;
    logic                    destWriteReg;
    bsralu_flags_type        flagsReg;
    logic                    next_resultValid;
    logic [WIDTH-1:0]        next_result;
    logic                    next_destWrite;
    bsralu_flags_type        next_flags;

    logic [INDEX_WIDTH-1:0]  scanUp;
    logic [INDEX_WIDTH-1:0]  scanDown;
    logic                    scanFound;

    bsr_alu_scan #(
        .WIDTH     (WIDTH)
    ) u_scan (
        .value     (req.src),
        .wordSize  (req.wordSize),
        .upIndex   (scanUp),
        .downIndex (scanDown),
        .found     (scanFound)
    );

    // Operand width and count helpers
    logic [6:0]              opWidth;
    logic [5:0]              cnt;
    logic [WIDTH-1:0]        mask;
    logic [WIDTH-1:0]        dst;
    logic [WIDTH-1:0]        srcv;
    logic [2*WIDTH-1:0]      pairLeft;
    logic [2*WIDTH-1:0]      pairRight;
    logic [WIDTH-1:0]        bitSel;
    logic [INDEX_WIDTH-1:0]  bitIdx;
    logic                    condTrue;
    logic [WIDTH-1:0]        andValue;
    int unsigned             rotN;
    int unsigned             rcN;

    always_comb
    begin
        opWidth  = req.wordSize ? 7'(WIDTH / 2) : 7'(WIDTH);
        cnt      = {1'b0, req.count};
        mask     = size_mask(req.wordSize);
        dst      = req.dest & mask;
        srcv     = req.src & mask;
        // Left pair: destination on top, source below; right pair: source on top; shift the pair as one string
        pairLeft  = req.wordSize
                  ? {{(WIDTH/2){1'b0}}, dst[WIDTH/2-1:0], srcv[WIDTH/2-1:0],
                     {(WIDTH/2){1'b0}}}
                  : {dst, srcv};
        pairRight = req.wordSize
                  ? {{(WIDTH){1'b0}}, srcv[WIDTH/2-1:0], dst[WIDTH/2-1:0]}
                  : {srcv, dst};
        rotN     = 32'(cnt) % 32'(opWidth);
        rcN      = 32'(cnt) % (32'(opWidth) + 32'd1);
        bitIdx   = req.wordSize ? {1'b0, req.count[INDEX_WIDTH-2:0]} : req.count;
        bitSel   = WIDTH'(1) << bitIdx;
        andValue = req.dest & req.src & mask;
    end

    // Flag condition decode for the conditional byte set
    always_comb
    begin
        case (req.cond)
            COND_OVERFLOW:      condTrue = flagsIn.overflowFlag;
            COND_NO_OVERFLOW:   condTrue = !flagsIn.overflowFlag;
            COND_CARRY:         condTrue = flagsIn.carryFlag;
            COND_NO_CARRY:      condTrue = !flagsIn.carryFlag;
            COND_ZERO:          condTrue = flagsIn.zeroFlag;
            COND_NOT_ZERO:      condTrue = !flagsIn.zeroFlag;
            COND_CARRY_OR_ZERO: condTrue = flagsIn.carryFlag | flagsIn.zeroFlag;
            COND_ABOVE:         condTrue = !(flagsIn.carryFlag | flagsIn.zeroFlag);
            COND_SIGN:          condTrue = flagsIn.signFlag;
            COND_NO_SIGN:       condTrue = !flagsIn.signFlag;
            COND_PARITY:        condTrue = flagsIn.parityFlag;
            COND_NO_PARITY:     condTrue = !flagsIn.parityFlag;
            COND_LESS:          condTrue = flagsIn.signFlag ^ flagsIn.overflowFlag;
            COND_GREATER_EQUAL: condTrue = !(flagsIn.signFlag ^ flagsIn.overflowFlag);
            COND_LESS_EQUAL:    condTrue = (flagsIn.signFlag ^ flagsIn.overflowFlag)
                                           | flagsIn.zeroFlag;
            default:            condTrue = !((flagsIn.signFlag ^ flagsIn.overflowFlag)
                                           | flagsIn.zeroFlag);
        endcase
    end

    // Result and flag computation, registered one cycle later
    logic [2*WIDTH-1:0]  shiftedL;
    logic [2*WIDTH-1:0]  shiftedR;
    logic [2*WIDTH-1:0]  rotDouble;
    logic [2*WIDTH+1:0]  rcDouble;
    logic [WIDTH:0]      rcStr;
    logic [WIDTH-1:0]    rotRes;

    always_comb
    begin
        next_resultValid = reqValid;
        next_result      = resultReg;
        next_destWrite   = 1'b0;
        next_flags       = flagsIn;
        shiftedL         = '0;
        shiftedR         = '0;
        rotDouble        = '0;
        rcDouble         = '0;
        rcStr            = '0;
        rotRes           = '0;
        if (reqValid)
        begin
            next_result = req.dest;
            case (req.op)
                OP_DOUBLE_SHIFT_LEFT:
                begin
                    if (cnt != '0)
                    begin
                        shiftedL    = pairLeft << cnt;
                        next_result = shiftedL[2*WIDTH-1:WIDTH] & mask;
                        next_destWrite = 1'b1;
                        // Last bit pushed out of the destination; zero for a word count above 16
                        if (req.wordSize)
                        begin
                            next_flags.carryFlag = (cnt > 6'(WIDTH/2))
                                ? 1'b0 : pairLeft[3*WIDTH/2 - 32'(cnt)];
                        end
                        else
                        begin
                            next_flags.carryFlag = pairLeft[2*WIDTH - 32'(cnt)];
                        end
                    end
                end
                OP_DOUBLE_SHIFT_RIGHT:
                begin
                    if (cnt != '0)
                    begin
                        shiftedR    = pairRight >> cnt;
                        next_result = shiftedR[WIDTH-1:0] & mask;
                        if (req.wordSize)
                        begin
                            next_result = {{(WIDTH/2){1'b0}}, shiftedR[WIDTH/2-1:0]};
                        end
                        next_destWrite = 1'b1;
                        next_flags.carryFlag = pairRight[32'(cnt) - 1];
                    end
                end
                OP_ROTATE_LEFT_PLAIN, OP_ROTATE_RIGHT_PLAIN:
                begin
                    if (cnt != '0)
                    begin
                        rotDouble = req.wordSize
                            ? {{(WIDTH){1'b0}}, dst[WIDTH/2-1:0], dst[WIDTH/2-1:0]}
                            : {dst, dst};
                        if (req.op == OP_ROTATE_LEFT_PLAIN)
                        begin
                            rotDouble = rotDouble << rotN;
                            rotRes = req.wordSize
                                ? {{(WIDTH/2){1'b0}}, rotDouble[WIDTH-1:WIDTH/2]}
                                : rotDouble[2*WIDTH-1:WIDTH];
                            next_flags.carryFlag = rotRes[0];
                        end
                        else
                        begin
                            rotDouble = rotDouble >> rotN;
                            rotRes = rotDouble[WIDTH-1:0] & mask;
                            next_flags.carryFlag = rotRes[32'(opWidth) - 1];
                        end
                        next_result    = rotRes;
                        next_destWrite = 1'b1;
                    end
                end
                OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY:
                begin
                    if (cnt != '0)
                    begin
                        // Carry as one extra bit above the operand
                        rcStr = req.wordSize
                            ? {{(WIDTH/2){1'b0}}, flagsIn.carryFlag, dst[WIDTH/2-1:0]}
                            : {flagsIn.carryFlag, dst};
                        // Copies must abut so the word string wraps at its own width
                        rcDouble = req.wordSize
                            ? {{(WIDTH){1'b0}}, rcStr[WIDTH/2:0], rcStr[WIDTH/2:0]}
                            : {rcStr, rcStr};
                        if (req.op == OP_ROTATE_LEFT_VIA_CARRY)
                        begin
                            rcDouble = rcDouble << rcN;
                            rcDouble = rcDouble >> (32'(opWidth) + 32'd1);
                        end
                        else
                        begin
                            rcDouble = rcDouble >> rcN;
                        end
                        next_result = rcDouble[WIDTH-1:0] & mask;
                        next_flags.carryFlag = rcDouble[32'(opWidth)];
                        next_destWrite = 1'b1;
                    end
                end
                OP_BIT_TEST_ONLY, OP_BIT_TEST_THEN_SET,
                OP_BIT_TEST_THEN_CLEAR, OP_BIT_TEST_THEN_INVERT:
                begin
                    next_flags.carryFlag = |(req.dest & bitSel);
                    case (req.op)
                        OP_BIT_TEST_THEN_SET:    next_result = req.dest | bitSel;
                        OP_BIT_TEST_THEN_CLEAR:  next_result = req.dest & ~bitSel;
                        OP_BIT_TEST_THEN_INVERT: next_result = req.dest ^ bitSel;
                        default:                 next_result = req.dest;
                    endcase
                    next_destWrite = (req.op != OP_BIT_TEST_ONLY);
                end
                OP_SCAN_UP_FIRST_ONE, OP_SCAN_DOWN_FIRST_ONE:
                begin
                    // Empty source: destination kept, zero flag raised
                    next_flags.zeroFlag = !scanFound;
                    if (scanFound)
                    begin
                        next_result = WIDTH'((req.op == OP_SCAN_UP_FIRST_ONE)
                                      ? scanUp : scanDown);
                        next_destWrite = 1'b1;
                    end
                end
                OP_CONDITIONAL_BYTE_SET:
                begin
                    next_result = {req.dest[WIDTH-1:8],
                                   condTrue ? BYTE_ONE : BYTE_ZERO};
                    next_destWrite = 1'b1;
                end
                OP_AND_TEST:
                begin
                    next_result = req.dest;
                    next_flags.signFlag   = andValue[32'(opWidth) - 1];
                    next_flags.zeroFlag   = (andValue == '0);
                    next_flags.parityFlag = even_parity(andValue);
                    next_flags.carryFlag    = 1'b0;
                    next_flags.overflowFlag = 1'b0;
                end
                default:
                begin
                    next_result = req.dest;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            resultValidReg <= 1'b0;
            resultReg      <= RESULT_RESET;
            destWriteReg   <= 1'b0;
            flagsReg       <= '{FLAG_RESET, FLAG_RESET, FLAG_RESET, FLAG_RESET, FLAG_RESET};
        end
        else
        begin
            resultValidReg <= next_resultValid;
            resultReg      <= next_result;
            destWriteReg   <= next_destWrite;
            flagsReg       <= next_flags;
        end
    end

    assign resultValid = resultValidReg;
    assign result      = resultReg;
    assign destWrite   = destWriteReg & resultValidReg;
    assign flagsOut    = flagsReg;

endmodule : bsr_alu

//--- test/bsr_alu_props.sv
// Concurrent checks on the ports of the bit shift and rotate datapath
`timescale 1ns/100ps
module bsr_alu_props
    import bsr_alu_pkg::*;
#(
    parameter int WIDTH = DATA_WIDTH
)
(
    input wire logic             clk,
    input wire logic             nrst,
    input wire logic             reqValid,
    input wire bsralu_req_type   req,
    input wire bsralu_flags_type flagsIn,
    input wire logic             resultValid,
    input wire logic [WIDTH-1:0] result,
    input wire logic             destWrite,
    input wire bsralu_flags_type flagsOut
);
    bsralu_req_type   pReq;
    bsralu_flags_type pFlags;
    logic [63:0]      rotWide;
    logic [63:0]      dblWide;
    logic [31:0]      bitMask;
    logic [31:0]      andVal;
    logic             full;
    logic             bitOp;

    // Request seen on the previous edge, lined up with its answer
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pReq   <= '0;
            pFlags <= '0;
        end
        else
        begin
            pReq   <= req;
            pFlags <= flagsIn;
        end
    end

    assign rotWide = {pReq.dest, pReq.dest} << pReq.count;
    assign dblWide = {pReq.dest, pReq.src} << pReq.count;
    assign bitMask = 32'h00000001 << pReq.count;
    assign andVal  = pReq.dest & pReq.src;
    assign full    = resultValid && !pReq.wordSize && pReq.count != 5'h00;
    assign bitOp   = resultValid && !pReq.wordSize;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence taken_s;
        reqValid;
    endsequence
    sequence answered_s;
        resultValid;
    endsequence

    resp_timing_a: assert property (taken_s |=> answered_s)
        else $error("no answer one cycle after a request");
    no_spurious_a: assert property (!reqValid |=> !resultValid && !destWrite)
        else $error("answer without a request");
    zero_count_a: assert property (
        resultValid && pReq.count == 5'h00 && pReq.op inside {OP_DOUBLE_SHIFT_LEFT,
        OP_DOUBLE_SHIFT_RIGHT, OP_ROTATE_LEFT_PLAIN, OP_ROTATE_RIGHT_PLAIN,
        OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY}
        |-> !destWrite && flagsOut.carryFlag == pFlags.carryFlag)
        else $error("zero count changed destination or carry");
    dshl_check_a: assert property (
        full && pReq.op == OP_DOUBLE_SHIFT_LEFT |-> result == dblWide[63:32]
        && destWrite && flagsOut.carryFlag == pReq.dest[6'd32 - pReq.count])
        else $error("double shift left result or carry wrong");
    rol_check_a: assert property (
        full && pReq.op == OP_ROTATE_LEFT_PLAIN
        |-> result == rotWide[63:32] && flagsOut.carryFlag == result[0])
        else $error("plain left rotate result or carry wrong");
    test_carry_a: assert property (
        bitOp && pReq.op inside {OP_BIT_TEST_ONLY, OP_BIT_TEST_THEN_SET,
        OP_BIT_TEST_THEN_CLEAR, OP_BIT_TEST_THEN_INVERT}
        |-> flagsOut.carryFlag == pReq.dest[pReq.count])
        else $error("bit test carry is not the old bit");
    bit_set_a: assert property (
        bitOp && pReq.op == OP_BIT_TEST_THEN_SET |-> result == (pReq.dest | bitMask))
        else $error("bit set result wrong");
    bit_invert_a: assert property (
        bitOp && pReq.op == OP_BIT_TEST_THEN_INVERT |-> result == (pReq.dest ^ bitMask))
        else $error("bit invert result wrong");
    set_overflow_a: assert property (
        resultValid && pReq.op == OP_CONDITIONAL_BYTE_SET && pReq.cond == COND_OVERFLOW
        |-> result[7:0] == (pFlags.overflowFlag ? BYTE_ONE : BYTE_ZERO))
        else $error("byte set on overflow wrong");
    and_test_a: assert property (
        bitOp && pReq.op == OP_AND_TEST |-> !destWrite
        && flagsOut.zeroFlag == (andVal == 32'h0) && flagsOut.signFlag == andVal[31])
        else $error("and test flags or write wrong");
endmodule : bsr_alu_props

bind bsr_alu bsr_alu_props #(.WIDTH(WIDTH)) u_bsr_alu_props (
    .clk(clk), .nrst(nrst), .reqValid(reqValid), .req(req), .flagsIn(flagsIn),
    .resultValid(resultValid), .result(result), .destWrite(destWrite), .flagsOut(flagsOut));

//--- test/bsr_alu_issuer.sv
// Model of the decode logic that issues requests and keeps the status flags
`timescale 1ns/100ps
module bsr_alu_issuer
    import bsr_alu_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             resultValid,
    input  wire bsralu_flags_type flagsOut,
    output logic                  reqValid,
    output bsralu_req_type        req,
    output bsralu_flags_type      flagsIn
);
    initial
    begin
        reqValid = 1'b0;
        req      = '0;
        flagsIn  = '0;
    end

    // Status flags register follows every answer
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            flagsIn <= '0;
        else if (resultValid)
            flagsIn <= flagsOut;
    end

    task automatic set_flags(input bsralu_flags_type f);
        @(negedge clk);
        flagsIn = f;
    endtask : set_flags

    // One width flag covers both operands
    task automatic issue(input bsralu_op_type op, input logic ws, input logic [31:0] d,
                         input logic [31:0] s, input logic [4:0] n, input bsralu_cond_type c);
        @(negedge clk);
        reqValid = 1'b1;
        req      = '{op, ws, d, s, n, c};
        @(negedge clk);
        reqValid = 1'b0;
        req.dest = ~d;
        req.src  = ~s;
    endtask : issue
endmodule : bsr_alu_issuer

//--- test/bsr_alu_tb_top.sv
// Self-checking testbench for the bit shift and rotate datapath
`timescale 1ns/100ps
module bsr_alu_tb_top
    import bsr_alu_pkg::*;
;
    localparam bsralu_flags_type F0 = 5'h00;
    localparam bsralu_flags_type FC = 5'h10;

    logic             clk;
    logic             nrst;
    logic             reqValid;
    bsralu_req_type   req;
    bsralu_flags_type flagsIn;
    logic             resultValid;
    logic [31:0]      result;
    logic             destWrite;
    bsralu_flags_type flagsOut;
    bsralu_flags_type fl;
    int               err_total;
    int               check_count;

    bsr_alu u_bsr_alu (.clk(clk), .nrst(nrst), .reqValid(reqValid), .req(req),
        .flagsIn(flagsIn), .resultValid(resultValid), .result(result),
        .destWrite(destWrite), .flagsOut(flagsOut));
    bsr_alu_issuer u_bsr_alu_issuer (.clk(clk), .nrst(nrst), .resultValid(resultValid),
        .flagsOut(flagsOut), .reqValid(reqValid), .req(req), .flagsIn(flagsIn));

    initial
        clk = 1'b0;
    always #10 clk = ~clk;

    task automatic expect_bits(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            err_total++;
    endtask : expect_bits

    task automatic chk(input bsralu_op_type op, input logic ws, input logic [31:0] d,
                       input logic [31:0] s, input logic [4:0] n, input bsralu_flags_type f,
                       input logic [31:0] expRes, input logic expWr, input logic expCarry);
        u_bsr_alu_issuer.set_flags(f);
        u_bsr_alu_issuer.issue(op, ws, d, s, n, COND_OVERFLOW);
        expect_bits({31'h0, resultValid}, 32'h00000001);
        expect_bits({31'h0, destWrite}, {31'h0, expWr});
        if (expWr)
            expect_bits(result, expRes);
        expect_bits({31'h0, flagsOut.carryFlag}, {31'h0, expCarry});
    endtask : chk

    function automatic logic cond_holds(input logic [3:0] c, input bsralu_flags_type f);
        logic b;
        case (c[3:1])
            3'h0:    b = f.overflowFlag;
            3'h1:    b = f.carryFlag;
            3'h2:    b = f.zeroFlag;
            3'h3:    b = f.carryFlag | f.zeroFlag;
            3'h4:    b = f.signFlag;
            3'h5:    b = f.parityFlag;
            3'h6:    b = f.signFlag ^ f.overflowFlag;
            default: b = (f.signFlag ^ f.overflowFlag) | f.zeroFlag;
        endcase
        return b ^ c[0];
    endfunction : cond_holds

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    initial
    begin
        #2000000;
        err_total++;
        report_and_stop();
    end

    initial
    begin
        err_total   = 0;
        check_count = 0;
        nrst        = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        chk(OP_DOUBLE_SHIFT_LEFT, 1'b0, 32'h12345678, 32'h9ABCDEF0, 5'h04, F0,
            32'h23456789, 1'b1, 1'b1);
        chk(OP_DOUBLE_SHIFT_LEFT, 1'b0, 32'h00000001, 32'h80000000, 5'h1F, FC,
            32'hC0000000, 1'b1, 1'b0);
        chk(OP_DOUBLE_SHIFT_RIGHT, 1'b0, 32'h12345678, 32'h0000000F, 5'h04, F0,
            32'hF1234567, 1'b1, 1'b1);
        chk(OP_DOUBLE_SHIFT_LEFT, 1'b0, 32'h12345678, 32'h0, 5'h00, FC, 32'h0, 1'b0, 1'b1);
        chk(OP_ROTATE_RIGHT_PLAIN, 1'b0, 32'h00000001, 32'h0, 5'h00, FC, 32'h0, 1'b0, 1'b1);
        chk(OP_ROTATE_LEFT_PLAIN, 1'b0, 32'h80000001, 32'h0, 5'h01, F0,
            32'h00000003, 1'b1, 1'b1);
        chk(OP_ROTATE_LEFT_PLAIN, 1'b0, 32'h00000002, 32'h0, 5'h1F, F0,
            32'h00000001, 1'b1, 1'b1);
        chk(OP_ROTATE_RIGHT_PLAIN, 1'b0, 32'h80000001, 32'h0, 5'h01, F0,
            32'hC0000000, 1'b1, 1'b1);
        chk(OP_ROTATE_LEFT_VIA_CARRY, 1'b0, 32'h40000000, 32'h0, 5'h01, FC,
            32'h80000001, 1'b1, 1'b0);
        chk(OP_ROTATE_RIGHT_VIA_CARRY, 1'b0, 32'h00000002, 32'h0, 5'h01, FC,
            32'h80000001, 1'b1, 1'b0);
        chk(OP_BIT_TEST_ONLY, 1'b0, 32'h00000100, 32'h0, 5'h08, F0, 32'h0, 1'b0, 1'b1);
        chk(OP_BIT_TEST_THEN_SET, 1'b0, 32'h00000100, 32'h0, 5'h09, FC,
            32'h00000300, 1'b1, 1'b0);
        chk(OP_BIT_TEST_THEN_CLEAR, 1'b0, 32'h00000100, 32'h0, 5'h08, F0,
            32'h00000000, 1'b1, 1'b1);
        chk(OP_BIT_TEST_THEN_INVERT, 1'b0, 32'h00000100, 32'h0, 5'h00, FC,
            32'h00000101, 1'b1, 1'b0);
        chk(OP_SCAN_UP_FIRST_ONE, 1'b0, 32'hFFFFFFFF, 32'h00008010, 5'h00, F0,
            32'h00000004, 1'b1, 1'b0);
        chk(OP_SCAN_UP_FIRST_ONE, 1'b0, 32'hFFFFFFFF, 32'h80000000, 5'h00, F0,
            32'h0000001F, 1'b1, 1'b0);
        chk(OP_SCAN_DOWN_FIRST_ONE, 1'b0, 32'hFFFFFFFF, 32'h00008010, 5'h00, F0,
            32'h0000000F, 1'b1, 1'b0);
        chk(OP_SCAN_DOWN_FIRST_ONE, 1'b0, 32'h1, 32'h0, 5'h00, F0, 32'h0, 1'b0, 1'b0);
        expect_bits({31'h0, flagsOut.zeroFlag}, 32'h00000001);
        chk(OP_DOUBLE_SHIFT_LEFT, 1'b1, 32'h00001234, 32'h0000ABCD, 5'h04, F0,
            32'h0000234A, 1'b1, 1'b1);
        chk(OP_ROTATE_LEFT_VIA_CARRY, 1'b1, 32'h00004000, 32'h0, 5'h01, FC,
            32'h00008001, 1'b1, 1'b0);
        chk(OP_ROTATE_RIGHT_VIA_CARRY, 1'b1, 32'h00000002, 32'h0, 5'h01, FC,
            32'h00008001, 1'b1, 1'b0);
        chk(OP_AND_TEST, 1'b0, 32'hF0F0F0F0, 32'h0F0F0F0F, 5'h00, FC, 32'h0, 1'b0, 1'b0);
        expect_bits({27'h0, flagsOut}, 32'h00000003);
        chk(OP_AND_TEST, 1'b0, 32'h800000FF, 32'h80000001, 5'h00, F0, 32'h0, 1'b0, 1'b0);
        expect_bits({27'h0, flagsOut}, 32'h00000004);
        for (int k = 0; k < 32; k++)
        begin
            fl = (k < 16) ? 5'h15 : 5'h0A;
            u_bsr_alu_issuer.set_flags(fl);
            u_bsr_alu_issuer.issue(OP_CONDITIONAL_BYTE_SET, 1'b0, 32'hAABBCC55, 32'h0, 5'h00,
                                   bsralu_cond_type'(k[3:0]));
            expect_bits(result, {24'hAABBCC, 7'h00, cond_holds(k[3:0], fl)});
        end
        @(negedge clk);
        nrst = 1'b0;
        @(negedge clk);
        expect_bits({31'h0, resultValid}, 32'h0);
        expect_bits(result, 32'h0);
        nrst = 1'b1;
        chk(OP_ROTATE_LEFT_PLAIN, 1'b1, 32'h00008001, 32'h0, 5'h01, F0,
            32'h00000003, 1'b1, 1'b1);
        report_and_stop();
    end
endmodule : bsr_alu_tb_top
